// file: verilog/ddt_map.svh
// register offsets, field positions, reset values and timing counts for the dual timer
`ifndef DDT_MAP_SVH
`define DDT_MAP_SVH
`define DDT_OFS_LOAD1    12'h000
`define DDT_OFS_VALUE1   12'h004
`define DDT_OFS_CTRL1    12'h008
`define DDT_OFS_ICLR1    12'h00c
`define DDT_OFS_RIS1     12'h010
`define DDT_OFS_MIS1     12'h014
`define DDT_OFS_BGLOAD1  12'h018
`define DDT_OFS_STRIDE   12'h020
`define DDT_OFS_ID0      12'hfe0
`define DDT_OFS_ID1      12'hfe4
`define DDT_CTRL_ONESHOT 0
`define DDT_CTRL_SIZE32  1
`define DDT_CTRL_PRE_LO  2
`define DDT_CTRL_IRQEN   5
`define DDT_CTRL_PERIOD  6
`define DDT_CTRL_RUN     7
`define DDT_CTRL_RESET   8'h20
`define DDT_VALUE_RESET  32'h0fffffff
`define DDT_LOAD_RESET   32'h00000000
`define DDT_PRE_DIV16    8'h0f
`define DDT_PRE_DIV256   8'hff
`define DDT_ID0_VALUE    32'h0000d7e1
`define DDT_ID1_VALUE    32'h00000001
`endif

// file: verilog/ddt_pkg.sv
// types shared by the dual down counter timer
package ddt_pkg;
   // control fields of one counter
   typedef struct packed {
      logic       run;
      logic       periodic;
      logic       irq_en;
      logic [1:0] pre;
      logic       size32;
      logic       oneshot;
   } ddt_ctrl_s;
   // register side command to one counter
   typedef struct packed {
      logic        load_wr;
      logic        bgload_wr;
      logic        irq_clr;
      logic [31:0] wdata;
   } ddt_cmd_s;
endpackage

// file: verilog/ddt_counter.sv
// one down counter with prescaler, modes and sticky zero flag
`timescale 1ns/1ps
`include "ddt_map.svh"
module ddt_counter
   import ddt_pkg::*;
(
   input  wire logic      clk_sys,
   input  wire logic      rst,
   input  wire logic      count_enable,
   input  wire ddt_ctrl_s ctrl,
   input  wire ddt_cmd_s  cmd,
   output logic [31:0]    load_val,
   output logic [31:0]    count_val,
   output logic           raw_irq
);
   typedef struct packed {
      logic [31:0] load;
      logic [31:0] count;
      logic [7:0]  pre_cnt;
      logic        pend_load;
      logic        halted;
      logic        irq;
   } ddt_cnt_state_s;

   ddt_cnt_state_s s_r;
   ddt_cnt_state_s s_nxt;
   logic [7:0]     pre_top;
   logic           pre_tick;
   logic           at_zero;

   // prescaler terminal count and zero detect
   always_comb begin
      unique case (ctrl.pre)
         2'd1:    pre_top = `DDT_PRE_DIV16;
         2'd2:    pre_top = `DDT_PRE_DIV256;
         default: pre_top = 8'h00;
      endcase
      pre_tick = (s_r.pre_cnt == 8'h00);
      // [R19] upper half ignored
      at_zero  = ctrl.size32 ? (s_r.count == 32'h0) : (s_r.count[15:0] == 16'h0);
   end

   // next state of the counter
   always_comb begin
      s_nxt = s_r;
      if (cmd.load_wr || cmd.bgload_wr) begin
         s_nxt.load = cmd.wdata;
      end
      // [R6] load write restarts
      if (cmd.load_wr) begin
         s_nxt.pend_load = 1'b1;
         s_nxt.halted    = 1'b0;
      end
      // [R11] prescaler gated by enable
      if (count_enable && ctrl.run) begin
         s_nxt.pre_cnt = pre_tick ? pre_top : s_r.pre_cnt - 8'h01;
      end
      // [R20] cleared run freezes count
      if (count_enable && ctrl.run && s_r.pend_load && !cmd.load_wr) begin
         s_nxt.count     = s_r.load;
         s_nxt.pend_load = 1'b0;
         s_nxt.pre_cnt   = pre_top;
      // [R12] decrement on both enables
      end else if (count_enable && ctrl.run && pre_tick && !s_r.halted
                   && !s_r.pend_load) begin
         if (at_zero) begin
            // [R8] zero raises flag
            s_nxt.irq = 1'b1;
            if (ctrl.oneshot) begin
               // [R5] one-shot halts
               s_nxt.halted = 1'b1;
            end else if (ctrl.periodic) begin
               // [R4] [R7] reload from load value
               if (ctrl.size32) s_nxt.count = s_r.load;
               else s_nxt.count[15:0] = s_r.load[15:0];
            end else begin
               // [R3] [R19] wrap to maximum
               if (ctrl.size32) s_nxt.count = 32'hffffffff;
               else s_nxt.count[15:0] = 16'hffff;
            end
         end else if (ctrl.size32) begin
            s_nxt.count = s_r.count - 32'h1;
         end else begin
            s_nxt.count[15:0] = s_r.count[15:0] - 16'h1;
         end
      end
      // [R21] [R23] clear only by software, set wins only when the flag was clear
      if (cmd.irq_clr && !(s_nxt.irq && !s_r.irq)) begin
         s_nxt.irq = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_r <= '{load: `DDT_LOAD_RESET, count: `DDT_VALUE_RESET, pre_cnt: 8'h00,
                  pend_load: 1'b0, halted: 1'b0, irq: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign load_val  = s_r.load;
   assign count_val = s_r.count;
   assign raw_irq   = s_r.irq;
endmodule

// file: verilog/ddt_top.sv
// dual down counter timer with an AXI4-Lite register slave
//
// Functional notes
// [R1] two counters, each 32 or 16 bit
// [R2] prescaler divides by 1, 16, 256
// [R3] free-running wraps to maximum at zero
// [R4] periodic reloads from load at zero
// [R5] one-shot halts at zero until reloaded
// [R6] load write restarts count at once
// [R7] background load waits for next reload
// [R8] zero raises interrupt, clear register clears
// [R9] per-counter interrupt mask
// [R10] value register readable any time
// [R11] prescaler steps only with count enable
// [R12] counter steps on enable and prescale tick
// [R13] defined reset state for each counter
// [R14] reset held one cycle, released synchronously
// [R15] timer clock synchronous, not above bus
// [R16] bus slave decodes, counters on clock
// [R17] shared clock, separate count enables
// [R18] read-only identification registers
// [R19] 16-bit mode uses low half only
// [R20] run bit freezes and resumes count
// [R21] clear drops interrupt output immediately
// [R22] raw and masked status registers
// [R23] raw status sticky until cleared
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "ddt_map.svh"
module ddt_top
   import ddt_pkg::*;
#(
   parameter logic [31:0] ID0_VALUE = `DDT_ID0_VALUE, // arbitrary identification value
   parameter logic [31:0] ID1_VALUE = `DDT_ID1_VALUE  // arbitrary identification value
)(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        count_enable_first,
   input  wire logic        count_enable_second,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             counter_irq_out_first,
   output logic             counter_irq_out_second,
   output logic             counter_irq_out_either
);
   // whole bus-side state
   typedef struct packed {
      logic        aw_full;
      logic [11:0] aw_addr;
      logic        w_full;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      ddt_ctrl_s   ctrl0;
      ddt_ctrl_s   ctrl1;
      logic        irq0;
      logic        irq1;
      logic        irqx;
   } ddt_top_state_s;

   ddt_top_state_s s_r;
   ddt_top_state_s s_nxt;
   ddt_cmd_s       cmd [2];
   logic [31:0]    load_val [2];
   logic [31:0]    count_val [2];
   logic [1:0]     raw_irq;
   logic [1:0]     cen;
   logic           do_write;

   // counter slot of an address, or 2 when outside the counter area
   function automatic logic [1:0] slot_of(input logic [11:0] a);
      if (a < `DDT_OFS_STRIDE) slot_of = 2'd0;
      else if (a < (`DDT_OFS_STRIDE << 1)) slot_of = 2'd1;
      else slot_of = 2'd2;
   endfunction

   // register offset inside a counter slot
   function automatic logic [11:0] reg_of(input logic [11:0] a);
      reg_of = {7'h00, a[4:2], 2'b00};
   endfunction

   // control byte packed as seen by software
   function automatic logic [31:0] ctrl_word(input ddt_ctrl_s c);
      ctrl_word = 32'h0;
      ctrl_word[`DDT_CTRL_ONESHOT]              = c.oneshot;
      ctrl_word[`DDT_CTRL_SIZE32]               = c.size32;
      ctrl_word[`DDT_CTRL_PRE_LO+1:`DDT_CTRL_PRE_LO] = c.pre;
      ctrl_word[`DDT_CTRL_IRQEN]                = c.irq_en;
      ctrl_word[`DDT_CTRL_PERIOD]               = c.periodic;
      ctrl_word[`DDT_CTRL_RUN]                  = c.run;
   endfunction

   function automatic ddt_ctrl_s ctrl_from(input logic [31:0] w);
      ctrl_from.oneshot  = w[`DDT_CTRL_ONESHOT];
      ctrl_from.size32   = w[`DDT_CTRL_SIZE32];
      ctrl_from.pre      = w[`DDT_CTRL_PRE_LO+1:`DDT_CTRL_PRE_LO];
      ctrl_from.irq_en   = w[`DDT_CTRL_IRQEN];
      ctrl_from.periodic = w[`DDT_CTRL_PERIOD];
      ctrl_from.run      = w[`DDT_CTRL_RUN];
   endfunction

   // [R17] separate enables per counter
   assign cen      = {count_enable_second, count_enable_first};
   assign do_write = s_r.aw_full && s_r.w_full && !s_r.bvalid;

   // [R1] two identical counters
   generate
      for (genvar i = 0; i < 2; i++) begin : g_cnt
         // write strobes for this counter
         always_comb begin
            cmd[i].wdata     = s_r.w_data;
            cmd[i].load_wr   = do_write && slot_of(s_r.aw_addr) == 2'(i)
                               && reg_of(s_r.aw_addr) == `DDT_OFS_LOAD1;
            cmd[i].bgload_wr = do_write && slot_of(s_r.aw_addr) == 2'(i)
                               && reg_of(s_r.aw_addr) == `DDT_OFS_BGLOAD1;
            cmd[i].irq_clr   = do_write && slot_of(s_r.aw_addr) == 2'(i)
                               && reg_of(s_r.aw_addr) == `DDT_OFS_ICLR1;
         end
         ddt_counter u_cnt (
            .clk_sys      (clk_sys),
            .rst          (rst),
            .count_enable (cen[i]),
            .ctrl         (i == 0 ? s_r.ctrl0 : s_r.ctrl1),
            .cmd          (cmd[i]),
            .load_val     (load_val[i]),
            .count_val    (count_val[i]),
            .raw_irq      (raw_irq[i])
         );
      end
   endgenerate

   // [R16] bus slave and register file
   always_comb begin
      logic [1:0]  rs;
      logic [11:0] ro;
      logic        mis0;
      logic        mis1;
      logic [31:0] rd;
      logic        ok;
      rs    = slot_of(s_axi_araddr);
      ro    = reg_of(s_axi_araddr);
      mis0  = 1'b0;
      mis1  = 1'b0;
      rd    = 32'h0;
      ok    = 1'b1;
      s_nxt = s_r;
      // accept address and data in either order
      if (s_axi_awvalid && !s_r.aw_full) begin
         s_nxt.aw_full = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !s_r.w_full) begin
         s_nxt.w_full = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         s_nxt.aw_full = 1'b0;
         s_nxt.w_full  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = 2'b00;
         if (slot_of(s_r.aw_addr) == 2'd2) begin
            s_nxt.bresp = 2'b10;
         end else if (reg_of(s_r.aw_addr) == `DDT_OFS_CTRL1 && s_r.w_strb[0]) begin
            if (slot_of(s_r.aw_addr) == 2'd0) s_nxt.ctrl0 = ctrl_from(s_r.w_data);
            else s_nxt.ctrl1 = ctrl_from(s_r.w_data);
         end
      end
      if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      // read decode
      if (s_axi_arvalid && !s_r.rvalid) begin
         if (rs != 2'd2) begin
            unique case (ro)
               `DDT_OFS_LOAD1, `DDT_OFS_BGLOAD1: rd = load_val[rs[0]];
               // [R10] value readable any time
               `DDT_OFS_VALUE1: rd = count_val[rs[0]];
               `DDT_OFS_CTRL1:  rd = ctrl_word(rs[0] ? s_r.ctrl1 : s_r.ctrl0);
               // [R22] raw and masked status
               `DDT_OFS_RIS1:   rd = {31'h0, raw_irq[rs[0]]};
               `DDT_OFS_MIS1:   rd = {31'h0, rs[0] ? s_r.irq1 : s_r.irq0};
               `DDT_OFS_ICLR1:  rd = 32'h0;
               default:         ok = 1'b0;
            endcase
         // [R18] identification words
         end else if (s_axi_araddr == `DDT_OFS_ID0) begin
            rd = ID0_VALUE;
         end else if (s_axi_araddr == `DDT_OFS_ID1) begin
            rd = ID1_VALUE;
         end else begin
            ok = 1'b0;
         end
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata  = rd;
         s_nxt.rresp  = ok ? 2'b00 : 2'b10;
      end else if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      // [R9] [R21] masked outputs, dropped in the clear cycle
      mis0 = raw_irq[0] && s_r.ctrl0.irq_en && !cmd[0].irq_clr;
      mis1 = raw_irq[1] && s_r.ctrl1.irq_en && !cmd[1].irq_clr;
      s_nxt.irq0 = mis0;
      s_nxt.irq1 = mis1;
      s_nxt.irqx = mis0 || mis1;
   end

   // [R13] reset state: stopped, free-running, 16 bit, divide 1, mask open
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_r       <= '0;
         s_r.ctrl0 <= ddt_ctrl_s'(7'(`DDT_CTRL_RESET >> 1));
         s_r.ctrl1 <= ddt_ctrl_s'(7'(`DDT_CTRL_RESET >> 1));
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready          = !s_r.aw_full;
   assign s_axi_wready           = !s_r.w_full;
   assign s_axi_bvalid           = s_r.bvalid;
   assign s_axi_bresp            = s_r.bresp;
   assign s_axi_arready          = !s_r.rvalid;
   assign s_axi_rvalid           = s_r.rvalid;
   assign s_axi_rdata            = s_r.rdata;
   assign s_axi_rresp            = s_r.rresp;
   assign counter_irq_out_first  = s_r.irq0;
   assign counter_irq_out_second = s_r.irq1;
   assign counter_irq_out_either = s_r.irqx;
endmodule

// file: tb/ddt_top_properties.sv
// concurrent checks on the dual timer bus and interrupt outputs
`timescale 1ns/1ps
`include "ddt_map.svh"
module ddt_top_properties (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        counter_irq_out_first,
   input wire logic        counter_irq_out_second,
   input wire logic        counter_irq_out_either
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // both write channels taken on one edge
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // no write can complete on this edge
   sequence s_no_wr;
      s_axi_awready && s_axi_wready && !s_axi_awvalid && !s_axi_wvalid;
   endsequence
   property p_wr_ans;
      s_wr |=> ##1 s_axi_bvalid;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_rd_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
   property p_r_done;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
   endproperty
   a_r_done: assert property (p_r_done) else $error("read not closed");
   property p_either;
      counter_irq_out_either == (counter_irq_out_first || counter_irq_out_second);
   endproperty
   a_either: assert property (p_either) else $error("combined irq wrong");
   property p_clr1;
      s_wr ##0 (s_axi_awaddr == `DDT_OFS_ICLR1) |=> ##1 !counter_irq_out_first;
   endproperty
   a_clr1: assert property (p_clr1) else $error("irq one not cleared");
   property p_clr2;
      s_wr ##0 (s_axi_awaddr == `DDT_OFS_ICLR1 + `DDT_OFS_STRIDE)
         |=> ##1 !counter_irq_out_second;
   endproperty
   a_clr2: assert property (p_clr2) else $error("irq two not cleared");
   property p_sticky;
      counter_irq_out_first ##0 s_no_wr |=> counter_irq_out_first;
   endproperty
   a_sticky: assert property (p_sticky) else $error("irq one fell alone");
endmodule
bind ddt_top ddt_top_properties u_props (.*);

// file: tb/ddt_en_src.sv
// count enable source pulsing once every gap plus one cycles
`timescale 1ns/1ps
module ddt_en_src (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [1:0] gap,
   output logic            en
);
   logic [1:0] cnt_r;
   // enable launched from the shared clock edge
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cnt_r <= 2'h0;
      end else if (cnt_r >= gap) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end
   assign en = (cnt_r == gap);
endmodule

// file: tb/ddt_top_tb.sv
// self-checking bench for the dual down counter timer
`timescale 1ns/1ps
`include "ddt_map.svh"
module ddt_top_tb;
   localparam logic [31:0] ID0 = 32'h00005a5a; // arbitrary identification value
   localparam logic [31:0] ID1 = 32'h00000003; // arbitrary identification value
   localparam logic [11:0] C2  = `DDT_OFS_STRIDE;
   logic        clk_sys, rst, count_enable_first;
   wire logic   count_enable_second;
   logic [1:0]  gap, resp, s_axi_bresp, s_axi_rresp;
   logic [11:0] s_axi_awaddr, s_axi_araddr, b;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [3:0]  s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, v, w, u;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic        counter_irq_out_first, counter_irq_out_second, counter_irq_out_either;
   int          mismatches, check_count, f;
   ddt_top #(.ID0_VALUE(ID0), .ID1_VALUE(ID1)) dut (.*);
   ddt_en_src u_en (.clk_sys(clk_sys), .rst(rst), .gap(gap), .en(count_enable_second));
   // system clock
   always #25 clk_sys = ~clk_sys;
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("FAIL %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic ok(input string nm, input logic c);
      chk(nm, 32'h1, {31'h0, c});
   endtask
   task automatic tmo;
      chk("handshake", 32'h1, 32'h0);
      close_out();
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk_sys);
   endtask
   // bus write: both channels offered, each released when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 200);
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
      if (n >= 200) tmo();
   endtask
   // bus read into v
   task automatic rd(input logic [11:0] a);
      int n;
      n = 0;
      @(posedge clk_sys);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 200);
      s_axi_rready <= 1'b0;
      v = s_axi_rdata;
      resp = s_axi_rresp;
      if (n >= 200) tmo();
   endtask
   // main sequence
   initial begin
      clk_sys = 1'b0;
      rst = 1'b1;
      count_enable_first = 1'b1;
      gap = 2'h1;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      mismatches = 0;
      check_count = 0;
      cyc(10);
      rst <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         b = i ? C2 : 12'h000;
         rd(b + `DDT_OFS_CTRL1);
         chk("ctrl", {24'h0, `DDT_CTRL_RESET}, v);
         rd(b + `DDT_OFS_LOAD1);
         chk("load", `DDT_LOAD_RESET, v);
         rd(b + `DDT_OFS_VALUE1);
         chk("value", `DDT_VALUE_RESET, v);
         rd(b + `DDT_OFS_RIS1);
         chk("ris", 32'h0, v);
      end
      rd(`DDT_OFS_ID0);
      chk("id0", ID0, v);
      rd(`DDT_OFS_ID1);
      chk("id1", ID1, v);
      wr(12'h100, 32'h0);
      chk("wr resp", 32'h2, {30'h0, resp});
      rd(12'h100);
      chk("rd resp", 32'h2, {30'h0, resp});
      $display("test reset done");
      wr(`DDT_OFS_LOAD1, 32'd1000);
      wr(`DDT_OFS_CTRL1, 32'ha2);
      wr(`DDT_OFS_CTRL1, 32'h22);
      rd(`DDT_OFS_VALUE1);
      w = v;
      ok("started", w <= 1000 && w > 990);
      cyc(20);
      rd(`DDT_OFS_VALUE1);
      chk("frozen", w, v);
      wr(`DDT_OFS_CTRL1, 32'ha2);
      cyc(20);
      rd(`DDT_OFS_VALUE1);
      ok("resume", v < w && v > w - 40);
      wr(`DDT_OFS_CTRL1, 32'ha0);
      wr(`DDT_OFS_LOAD1, 32'd5);
      cyc(20);
      rd(`DDT_OFS_RIS1);
      chk("ris1", 32'h1, v);
      ok("irq1", counter_irq_out_first && counter_irq_out_either);
      rd(`DDT_OFS_VALUE1);
      ok("wrap16", v[31:16] == 16'h0 && v[15:0] > 16'hff00);
      wr(`DDT_OFS_ICLR1, 32'h0);
      ok("clr1", !counter_irq_out_first);
      rd(`DDT_OFS_RIS1);
      chk("ris1 clr", 32'h0, v);
      $display("test free-running done");
      wr(C2 + `DDT_OFS_LOAD1, 32'd40);
      wr(C2 + `DDT_OFS_CTRL1, 32'he2);
      wr(C2 + `DDT_OFS_BGLOAD1, 32'd3000);
      rd(C2 + `DDT_OFS_VALUE1);
      ok("bg kept", v <= 40 && v > 20);
      cyc(100);
      rd(C2 + `DDT_OFS_VALUE1);
      ok("reload", v > 2900 && v <= 3000);
      ok("irq2", counter_irq_out_second);
      wr(C2 + `DDT_OFS_CTRL1, 32'hc2);
      rd(C2 + `DDT_OFS_MIS1);
      chk("mis2", 32'h0, v);
      ok("masked", !counter_irq_out_second);
      rd(C2 + `DDT_OFS_RIS1);
      chk("ris2", 32'h1, v);
      wr(C2 + `DDT_OFS_ICLR1, 32'h0);
      rd(C2 + `DDT_OFS_RIS1);
      chk("ris2 clr", 32'h0, v);
      $display("test periodic done");
      wr(`DDT_OFS_CTRL1, 32'ha3);
      wr(`DDT_OFS_LOAD1, 32'd10);
      cyc(40);
      rd(`DDT_OFS_VALUE1);
      chk("halted", 32'h0, v);
      wr(`DDT_OFS_LOAD1, 32'd2000);
      rd(`DDT_OFS_VALUE1);
      ok("retrig", v > 1980 && v <= 2000);
      wr(`DDT_OFS_ICLR1, 32'h0);
      $display("test one-shot done");
      for (int p = 0; p < 3; p++) begin
         f = (p == 0) ? 1 : (p == 1) ? 16 : 256;
         wr(`DDT_OFS_LOAD1, 32'd100000);
         wr(`DDT_OFS_CTRL1, 32'ha2 + 32'(p * 4));
         rd(`DDT_OFS_VALUE1);
         w = v;
         cyc(512);
         rd(`DDT_OFS_VALUE1);
         ok("prescale", w - v >= 512 / f && w - v <= 520 / f + 1);
      end
      $display("test prescale done");
      wr(`DDT_OFS_CTRL1, 32'ha2);
      wr(C2 + `DDT_OFS_CTRL1, 32'ha2);
      count_enable_first <= 1'b0;
      rd(`DDT_OFS_VALUE1);
      w = v;
      rd(C2 + `DDT_OFS_VALUE1);
      u = v;
      cyc(20);
      rd(`DDT_OFS_VALUE1);
      chk("no enable", w, v);
      rd(C2 + `DDT_OFS_VALUE1);
      ok("own enable", v < u);
      $display("test enables done");
      close_out();
   end
endmodule
